// ==== rtl/bbls_master.sv ====
// Purpose: master end, runs one address/data transfer per start request
// Assumes: arbiter outside grants ownership; bus inputs are synchronous
// Notes: every user output and every bus output but the tied-low m_own_o and m_fail_o comes from a flip-flop
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - low line level means logic one
// - one driver per line set at once
// - enable drivers before use, disable after
// - enable, valid, remove, release in order
// - direction line high read, low write
// - width line low for longword only
// - strobe falling edge marks lines valid
// - shared lines only held low or released
// - address strobe rises after address released
module bbls_master #(
  parameter int SETTLE = bbls_pkg::SETTLE_CYC,
  parameter int ACK_TIMEOUT = bbls_pkg::ACK_TIMEOUT_CYC,
  parameter int OWN_LEVEL = 0
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_start,
  input wire logic i_write,
  input wire logic i_long,
  input wire logic [bbls_pkg::LANE_W-1:0] i_lanes,
  input wire logic [bbls_pkg::ADDR_W:1] i_addr,
  input wire logic [bbls_pkg::QUAL_W-1:0] i_qual,
  input wire logic [bbls_pkg::TEST_W-1:0] i_test,
  input wire logic [bbls_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_grant,
  input wire logic i_fail_hold,
  output logic o_busy,
  output logic o_done,
  output logic o_fault,
  output logic [bbls_pkg::DATA_W-1:0] o_rdata,
  output logic o_fail_seen,
  bbls_bus_if.master bus
);
  bbls_pkg::bbls_mst_state_t st_r, st_nxt;
  logic [bbls_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
  logic [bbls_pkg::ADDR_W:1] addr_r, addr_nxt;
  logic [bbls_pkg::QUAL_W-1:0] qual_r, qual_nxt;
  logic [bbls_pkg::TEST_W-1:0] test_r, test_nxt;
  logic [bbls_pkg::ACHK_W-1:0] achk_r, achk_nxt;
  logic dir_r, dir_nxt;
  logic wid_r, wid_nxt;
  logic aset_oe_r, aset_oe_nxt;
  logic [bbls_pkg::DATA_W-1:0] data_r, data_nxt;
  logic [bbls_pkg::DCHK_W-1:0] dchk_r, dchk_nxt;
  logic data_oe_r, data_oe_nxt;
  logic as_r, as_nxt;
  logic [bbls_pkg::LANE_W-1:0] ds_r, ds_nxt;
  logic [bbls_pkg::LANE_W-1:0] lanes_r, lanes_nxt;
  logic strb_oe_r, strb_oe_nxt;
  logic own_oe_r, own_oe_nxt;
  logic fail_oe_r, fail_oe_nxt;
  logic busy_r, busy_nxt;
  logic done_r, done_nxt;
  logic fault_r, fault_nxt;
  logic [bbls_pkg::DATA_W-1:0] rdata_r, rdata_nxt;
  logic fail_seen_r, fail_seen_nxt;
  logic ack_prev_r;
  logic flt_prev_r;
  logic ack_fall;
  logic flt_fall;
  logic resp_high;
  logic [bbls_pkg::OWN_W-1:0] own_sel;

  assign ack_fall = ack_prev_r & ~bus.transfer_acknowledge_n;
  assign flt_fall = flt_prev_r & ~bus.transfer_fault_n;
  assign resp_high = bus.transfer_acknowledge_n & bus.transfer_fault_n;
  assign own_sel = bbls_pkg::OWN_W'(1) << OWN_LEVEL;

  always_comb
  begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    addr_nxt = addr_r;
    qual_nxt = qual_r;
    test_nxt = test_r;
    achk_nxt = achk_r;
    dir_nxt = dir_r;
    wid_nxt = wid_r;
    aset_oe_nxt = aset_oe_r;
    data_nxt = data_r;
    dchk_nxt = dchk_r;
    data_oe_nxt = data_oe_r;
    as_nxt = as_r;
    ds_nxt = ds_r;
    lanes_nxt = lanes_r;
    strb_oe_nxt = strb_oe_r;
    own_oe_nxt = own_oe_r;
    busy_nxt = busy_r;
    done_nxt = 1'h0;
    fault_nxt = fault_r;
    rdata_nxt = rdata_r;
    fail_oe_nxt = i_fail_hold;
    fail_seen_nxt = ~bus.system_failure_n;
    unique case (st_r)
      bbls_pkg::BBLS_M_IDLE:
      begin
        if (i_start)
        begin
          addr_nxt = ~i_addr;
          qual_nxt = ~i_qual;
          test_nxt = ~i_test;
          achk_nxt = ~bbls_pkg::bbls_addr_chk(i_addr);
          data_nxt = ~i_wdata;
          dchk_nxt = ~bbls_pkg::bbls_data_chk(i_wdata);
          // high for read, low for write
          dir_nxt = ~i_write;
          wid_nxt = ~i_long;
          lanes_nxt = i_long ? bbls_pkg::LANES_ALL : i_lanes;
          busy_nxt = 1'h1;
          fault_nxt = 1'h0;
          own_oe_nxt = 1'h1;
          st_nxt = bbls_pkg::BBLS_M_REQ;
        end
      end
      bbls_pkg::BBLS_M_REQ:
      begin
        // drive only once ownership is granted
        if (i_grant)
        begin
          own_oe_nxt = 1'h0;
          aset_oe_nxt = 1'h1;
          data_oe_nxt = ~dir_r;
          strb_oe_nxt = 1'h1;
          as_nxt = bbls_pkg::LINE_HIGH;
          ds_nxt = bbls_pkg::LANES_HIGH;
          cnt_nxt = '0;
          st_nxt = bbls_pkg::BBLS_M_DRIVE;
        end
      end
      bbls_pkg::BBLS_M_DRIVE:
      begin
        // levels settle before the strobes fall
        if (cnt_r == bbls_pkg::CNT_W'(SETTLE - 1))
        begin
          as_nxt = bbls_pkg::LINE_LOW;
          st_nxt = bbls_pkg::BBLS_M_STROBE;
        end
        else
        begin
          cnt_nxt = cnt_r + 1'h1;
        end
      end
      bbls_pkg::BBLS_M_STROBE:
      begin
        // data strobes fall after the address strobe
        ds_nxt = ~lanes_r;
        cnt_nxt = '0;
        st_nxt = bbls_pkg::BBLS_M_WAIT;
      end
      bbls_pkg::BBLS_M_WAIT:
      begin
        if (ack_fall)
        begin
          // read data taken on the response fall
          if (dir_r)
          begin
            rdata_nxt = ~bus.data_lines;
          end
          ds_nxt = bbls_pkg::LANES_HIGH;
          st_nxt = bbls_pkg::BBLS_M_DSUP;
        end
        else if (flt_fall || cnt_r == bbls_pkg::CNT_W'(ACK_TIMEOUT - 1))
        begin
          fault_nxt = 1'h1;
          ds_nxt = bbls_pkg::LANES_HIGH;
          st_nxt = bbls_pkg::BBLS_M_DSUP;
        end
        else
        begin
          cnt_nxt = cnt_r + 1'h1;
        end
      end
      bbls_pkg::BBLS_M_DSUP:
      begin
        if (resp_high)
        begin
          aset_oe_nxt = 1'h0;
          data_oe_nxt = 1'h0;
          st_nxt = bbls_pkg::BBLS_M_RELEASE;
        end
      end
      bbls_pkg::BBLS_M_RELEASE:
      begin
        // address strobe rises after address release
        as_nxt = bbls_pkg::LINE_HIGH;
        st_nxt = bbls_pkg::BBLS_M_ASUP;
      end
      bbls_pkg::BBLS_M_ASUP:
      begin
        strb_oe_nxt = 1'h0;
        busy_nxt = 1'h0;
        done_nxt = 1'h1;
        st_nxt = bbls_pkg::BBLS_M_IDLE;
      end
      default:
      begin
        st_nxt = bbls_pkg::BBLS_M_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      st_r <= bbls_pkg::BBLS_M_IDLE;
      cnt_r <= '0;
      addr_r <= '1;
      qual_r <= '1;
      test_r <= '1;
      achk_r <= '1;
      dir_r <= bbls_pkg::LINE_HIGH;
      wid_r <= bbls_pkg::LINE_HIGH;
      aset_oe_r <= 1'h0;
      data_r <= '1;
      dchk_r <= '1;
      data_oe_r <= 1'h0;
      as_r <= bbls_pkg::LINE_HIGH;
      ds_r <= bbls_pkg::LANES_HIGH;
      lanes_r <= '0;
      strb_oe_r <= 1'h0;
      own_oe_r <= 1'h0;
      fail_oe_r <= 1'h0;
      busy_r <= 1'h0;
      done_r <= 1'h0;
      fault_r <= 1'h0;
      rdata_r <= '0;
      fail_seen_r <= 1'h0;
      ack_prev_r <= bbls_pkg::LINE_HIGH;
      flt_prev_r <= bbls_pkg::LINE_HIGH;
    end
    else
    begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      addr_r <= addr_nxt;
      qual_r <= qual_nxt;
      test_r <= test_nxt;
      achk_r <= achk_nxt;
      dir_r <= dir_nxt;
      wid_r <= wid_nxt;
      aset_oe_r <= aset_oe_nxt;
      data_r <= data_nxt;
      dchk_r <= dchk_nxt;
      data_oe_r <= data_oe_nxt;
      as_r <= as_nxt;
      ds_r <= ds_nxt;
      lanes_r <= lanes_nxt;
      strb_oe_r <= strb_oe_nxt;
      own_oe_r <= own_oe_nxt;
      fail_oe_r <= fail_oe_nxt;
      busy_r <= busy_nxt;
      done_r <= done_nxt;
      fault_r <= fault_nxt;
      rdata_r <= rdata_nxt;
      fail_seen_r <= fail_seen_nxt;
      ack_prev_r <= bus.transfer_acknowledge_n;
      flt_prev_r <= bus.transfer_fault_n;
    end
  end

  assign bus.m_addr_o = addr_r;
  assign bus.m_qual_o = qual_r;
  assign bus.m_test_o = test_r;
  assign bus.m_achk_o = achk_r;
  assign bus.m_write_n_o = dir_r;
  assign bus.m_wide_n_o = wid_r;
  assign bus.m_aset_oe = aset_oe_r;
  assign bus.m_data_o = data_r;
  assign bus.m_dchk_o = dchk_r;
  assign bus.m_data_oe = data_oe_r;
  assign bus.m_as_o = as_r;
  assign bus.m_ds_o = ds_r;
  assign bus.m_strb_oe = strb_oe_r;
  assign bus.m_own_o = '0;
  assign bus.m_own_oe = own_oe_r ? own_sel : '0;
  assign bus.m_fail_o = bbls_pkg::LINE_LOW;
  assign bus.m_fail_oe = fail_oe_r;
  assign o_busy = busy_r;
  assign o_done = done_r;
  assign o_fault = fault_r;
  assign o_rdata = rdata_r;
  assign o_fail_seen = fail_seen_r;
endmodule : bbls_master
`default_nettype wire

// ==== pkg/bbls_pkg.sv ====
// Purpose: shared constants and types for the backplane line signalling ends
// Assumes: one 125 MHz clock, bus inputs synchronous to it
// Notes: line levels are stored as driven, logic values are inverted
package bbls_pkg;
  localparam int CLK_PERIOD_NS = 8;
  localparam int SETTLE_NS = 16;
  // least time, rounded up to whole cycles
  localparam int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACK_TIMEOUT_CYC = 256;
  localparam int CNT_W = 16;
  localparam int ADDR_W = 31;
  localparam int DATA_W = 32;
  localparam int QUAL_W = 8;
  localparam int TEST_W = 2;
  localparam int ACHK_W = 2;
  localparam int DCHK_W = 4;
  localparam int OWN_W = 5;
  localparam int LANE_W = 2;
  localparam logic LINE_HIGH = 1'h1;
  localparam logic LINE_LOW = 1'h0;
  localparam logic [LANE_W-1:0] LANES_HIGH = 2'h3;
  localparam logic [LANE_W-1:0] LANES_ALL = 2'h3;

  typedef enum logic [3:0] {
    BBLS_M_IDLE = 4'h0,
    BBLS_M_REQ = 4'h1,
    BBLS_M_DRIVE = 4'h2,
    BBLS_M_STROBE = 4'h3,
    BBLS_M_WAIT = 4'h4,
    BBLS_M_DSUP = 4'h5,
    BBLS_M_RELEASE = 4'h6,
    BBLS_M_ASUP = 4'h7
  } bbls_mst_state_t;

  typedef enum logic [2:0] {
    BBLS_S_IDLE = 3'h0,
    BBLS_S_SEL = 3'h1,
    BBLS_S_RDV = 3'h2,
    BBLS_S_ACK = 3'h3,
    BBLS_S_END = 3'h4
  } bbls_slv_state_t;

  // even check bits over the logic value of the address, one per half
  function automatic logic [ACHK_W-1:0] bbls_addr_chk(
    input logic [ADDR_W:1] a
  );
    bbls_addr_chk = {^a[31:16], ^a[15:1]};
  endfunction : bbls_addr_chk

  // even check bits over the logic value of the data, one per byte
  function automatic logic [DCHK_W-1:0] bbls_data_chk(
    input logic [DATA_W-1:0] d
  );
    bbls_data_chk = {^d[31:24], ^d[23:16], ^d[15:8], ^d[7:0]};
  endfunction : bbls_data_chk
endpackage : bbls_pkg

// ==== pkg/bbls_bus_if.sv ====
// Purpose: backplane lines between a master end and a slave end
// Assumes: each party gives output, enable; the wire level is resolved here
// Notes: released lines read high, as the terminations would hold them
`timescale 1ns/1ps
`default_nettype none
interface bbls_bus_if;
  logic [bbls_pkg::ADDR_W:1] m_addr_o;
  logic [bbls_pkg::QUAL_W-1:0] m_qual_o;
  logic [bbls_pkg::TEST_W-1:0] m_test_o;
  logic [bbls_pkg::ACHK_W-1:0] m_achk_o;
  logic m_write_n_o;
  logic m_wide_n_o;
  logic m_aset_oe;
  logic [bbls_pkg::DATA_W-1:0] m_data_o;
  logic [bbls_pkg::DCHK_W-1:0] m_dchk_o;
  logic m_data_oe;
  logic m_as_o;
  logic [bbls_pkg::LANE_W-1:0] m_ds_o;
  logic m_strb_oe;
  logic [bbls_pkg::OWN_W-1:0] m_own_o;
  logic [bbls_pkg::OWN_W-1:0] m_own_oe;
  logic m_fail_o;
  logic m_fail_oe;
  logic [bbls_pkg::DATA_W-1:0] s_data_o;
  logic [bbls_pkg::DCHK_W-1:0] s_dchk_o;
  logic s_data_oe;
  logic s_ack_o;
  logic s_ack_oe;
  logic s_flt_o;
  logic s_flt_oe;
  logic s_fail_o;
  logic s_fail_oe;

  logic [bbls_pkg::ADDR_W:1] address_lines;
  logic [bbls_pkg::QUAL_W-1:0] address_qualifier_lines;
  logic [bbls_pkg::TEST_W-1:0] system_test_code_lines;
  logic [bbls_pkg::ACHK_W-1:0] address_check_bits;
  logic write_n;
  logic wide_transfer_n;
  logic [bbls_pkg::DATA_W-1:0] data_lines;
  logic [bbls_pkg::DCHK_W-1:0] data_check_bits;
  logic address_strobe_n;
  logic lane0_data_strobe_n;
  logic lane1_data_strobe_n;
  logic transfer_acknowledge_n;
  logic transfer_fault_n;
  logic [bbls_pkg::OWN_W-1:0] ownership_request_levels_n;
  logic system_failure_n;

  // three-state sets: undriven reads high
  assign address_lines = m_aset_oe ? m_addr_o : '1;
  assign address_qualifier_lines = m_aset_oe ? m_qual_o : '1;
  assign system_test_code_lines = m_aset_oe ? m_test_o : '1;
  assign address_check_bits = m_aset_oe ? m_achk_o : '1;
  assign write_n = m_aset_oe ? m_write_n_o : 1'h1;
  assign wide_transfer_n = m_aset_oe ? m_wide_n_o : 1'h1;
  assign data_lines = m_data_oe ? m_data_o : (s_data_oe ? s_data_o : '1);
  assign data_check_bits = m_data_oe ? m_dchk_o
                         : (s_data_oe ? s_dchk_o : '1);
  assign address_strobe_n = m_strb_oe ? m_as_o : 1'h1;
  assign lane0_data_strobe_n = m_strb_oe ? m_ds_o[0] : 1'h1;
  assign lane1_data_strobe_n = m_strb_oe ? m_ds_o[1] : 1'h1;
  // open-collector lines: any enabled low driver wins
  assign transfer_acknowledge_n = ~(s_ack_oe & ~s_ack_o);
  assign transfer_fault_n = ~(s_flt_oe & ~s_flt_o);
  assign ownership_request_levels_n = ~(m_own_oe & ~m_own_o);
  assign system_failure_n = ~((m_fail_oe & ~m_fail_o)
                              | (s_fail_oe & ~s_fail_o));

  modport master (
    output m_addr_o, m_qual_o, m_test_o, m_achk_o, m_write_n_o, m_wide_n_o,
    output m_aset_oe, m_data_o, m_dchk_o, m_data_oe, m_as_o, m_ds_o,
    output m_strb_oe, m_own_o, m_own_oe, m_fail_o, m_fail_oe,
    input data_lines, data_check_bits, transfer_acknowledge_n,
    input transfer_fault_n, system_failure_n
  );
  modport slave (
    output s_data_o, s_dchk_o, s_data_oe, s_ack_o, s_ack_oe,
    output s_flt_o, s_flt_oe, s_fail_o, s_fail_oe,
    input address_lines, address_qualifier_lines, system_test_code_lines,
    input address_check_bits, write_n, wide_transfer_n, data_lines,
    input data_check_bits, address_strobe_n, lane0_data_strobe_n,
    input lane1_data_strobe_n, system_failure_n
  );
endinterface : bbls_bus_if
`default_nettype wire

// ==== rtl/bbls_slave.sv ====
// Purpose: slave end, answers one transfer per address strobe
// Assumes: bus inputs synchronous; read data ready at the data strobe fall
// Notes: bad check bits answer with the fault line instead of acknowledge
`timescale 1ns/1ps
`default_nettype none
module bbls_slave #(
  parameter logic [bbls_pkg::ADDR_W:1] BASE = '0,
  parameter logic [bbls_pkg::ADDR_W:1] MASK = '0,
  parameter int SETTLE = bbls_pkg::SETTLE_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [bbls_pkg::DATA_W-1:0] i_rdata,
  input wire logic i_fail_hold,
  output logic o_req,
  output logic o_write,
  output logic o_long,
  output logic [bbls_pkg::LANE_W-1:0] o_lanes,
  output logic [bbls_pkg::ADDR_W:1] o_addr,
  output logic [bbls_pkg::QUAL_W-1:0] o_qual,
  output logic [bbls_pkg::TEST_W-1:0] o_test,
  output logic [bbls_pkg::DATA_W-1:0] o_wdata,
  output logic o_chk_err,
  output logic o_fail_seen,
  bbls_bus_if.slave bus
);
  bbls_pkg::bbls_slv_state_t st_r, st_nxt;
  logic [bbls_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
  logic as_prev_r;
  logic [bbls_pkg::LANE_W-1:0] ds_prev_r;
  logic [bbls_pkg::LANE_W-1:0] ds_now;
  logic as_fall, as_rise, ds_fall, ds_high;
  logic [bbls_pkg::ADDR_W:1] a_log;
  logic [bbls_pkg::DATA_W-1:0] d_log;
  logic bad_r, bad_nxt;
  logic req_r, req_nxt;
  logic write_r, write_nxt;
  logic long_r, long_nxt;
  logic [bbls_pkg::LANE_W-1:0] lanes_r, lanes_nxt;
  logic [bbls_pkg::ADDR_W:1] addr_r, addr_nxt;
  logic [bbls_pkg::QUAL_W-1:0] qual_r, qual_nxt;
  logic [bbls_pkg::TEST_W-1:0] test_r, test_nxt;
  logic [bbls_pkg::DATA_W-1:0] wdata_r, wdata_nxt;
  logic [bbls_pkg::DATA_W-1:0] sdata_r, sdata_nxt;
  logic [bbls_pkg::DCHK_W-1:0] sdchk_r, sdchk_nxt;
  logic sdata_oe_r, sdata_oe_nxt;
  logic ack_oe_r, ack_oe_nxt;
  logic flt_oe_r, flt_oe_nxt;
  logic chk_err_r, chk_err_nxt;
  logic fail_oe_r, fail_seen_r;

  assign ds_now = {bus.lane1_data_strobe_n, bus.lane0_data_strobe_n};
  // edges and high levels of the strobes carry meaning
  assign as_fall = as_prev_r & ~bus.address_strobe_n;
  assign as_rise = ~as_prev_r & bus.address_strobe_n;
  assign ds_fall = |(ds_prev_r & ~ds_now);
  assign ds_high = &ds_now;
  assign a_log = ~bus.address_lines;
  assign d_log = ~bus.data_lines;

  always_comb
  begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    bad_nxt = bad_r;
    req_nxt = 1'h0;
    write_nxt = write_r;
    long_nxt = long_r;
    lanes_nxt = lanes_r;
    addr_nxt = addr_r;
    qual_nxt = qual_r;
    test_nxt = test_r;
    wdata_nxt = wdata_r;
    sdata_nxt = sdata_r;
    sdchk_nxt = sdchk_r;
    sdata_oe_nxt = sdata_oe_r;
    ack_oe_nxt = ack_oe_r;
    flt_oe_nxt = flt_oe_r;
    chk_err_nxt = chk_err_r;
    unique case (st_r)
      bbls_pkg::BBLS_S_IDLE:
      begin
        // address sampled on the strobe fall
        if (as_fall)
        begin
          addr_nxt = a_log;
          qual_nxt = ~bus.address_qualifier_lines;
          test_nxt = ~bus.system_test_code_lines;
          write_nxt = ~bus.write_n;
          long_nxt = ~bus.wide_transfer_n;
          bad_nxt = bbls_pkg::bbls_addr_chk(a_log)
                    != ~bus.address_check_bits;
          if ((a_log & MASK) == (BASE & MASK))
          begin
            st_nxt = bbls_pkg::BBLS_S_SEL;
          end
          else
          begin
            st_nxt = bbls_pkg::BBLS_S_END;
          end
        end
      end
      bbls_pkg::BBLS_S_SEL:
      begin
        if (as_rise)
        begin
          st_nxt = bbls_pkg::BBLS_S_IDLE;
        end
        else if (ds_fall)
        begin
          lanes_nxt = ~ds_now;
          req_nxt = ~bad_r;
          chk_err_nxt = bad_r;
          if (bad_r)
          begin
            flt_oe_nxt = 1'h1;
            st_nxt = bbls_pkg::BBLS_S_ACK;
          end
          else if (write_r)
          begin
            // write data sampled on the strobe fall
            wdata_nxt = d_log;
            chk_err_nxt = bbls_pkg::bbls_data_chk(d_log)
                          != ~bus.data_check_bits;
            flt_oe_nxt = chk_err_nxt;
            ack_oe_nxt = ~chk_err_nxt;
            st_nxt = bbls_pkg::BBLS_S_ACK;
          end
          else
          begin
            // drive data only when the master reads
            sdata_nxt = ~i_rdata;
            sdchk_nxt = ~bbls_pkg::bbls_data_chk(i_rdata);
            sdata_oe_nxt = 1'h1;
            cnt_nxt = '0;
            st_nxt = bbls_pkg::BBLS_S_RDV;
          end
        end
      end
      bbls_pkg::BBLS_S_RDV:
      begin
        // data valid before the acknowledge falls
        if (cnt_r == bbls_pkg::CNT_W'(SETTLE - 1))
        begin
          ack_oe_nxt = 1'h1;
          st_nxt = bbls_pkg::BBLS_S_ACK;
        end
        else
        begin
          cnt_nxt = cnt_r + 1'h1;
        end
      end
      bbls_pkg::BBLS_S_ACK:
      begin
        // release data and response on strobe rise
        if (ds_high)
        begin
          sdata_oe_nxt = 1'h0;
          ack_oe_nxt = 1'h0;
          flt_oe_nxt = 1'h0;
          st_nxt = bbls_pkg::BBLS_S_END;
        end
      end
      bbls_pkg::BBLS_S_END:
      begin
        // address strobe high ends the transfer
        if (bus.address_strobe_n)
        begin
          st_nxt = bbls_pkg::BBLS_S_IDLE;
        end
      end
      default:
      begin
        st_nxt = bbls_pkg::BBLS_S_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      st_r <= bbls_pkg::BBLS_S_IDLE;
      cnt_r <= '0;
      as_prev_r <= bbls_pkg::LINE_HIGH;
      ds_prev_r <= bbls_pkg::LANES_HIGH;
      bad_r <= 1'h0;
      req_r <= 1'h0;
      write_r <= 1'h0;
      long_r <= 1'h0;
      lanes_r <= '0;
      addr_r <= '0;
      qual_r <= '0;
      test_r <= '0;
      wdata_r <= '0;
      sdata_r <= '1;
      sdchk_r <= '1;
      sdata_oe_r <= 1'h0;
      ack_oe_r <= 1'h0;
      flt_oe_r <= 1'h0;
      chk_err_r <= 1'h0;
      fail_oe_r <= 1'h0;
      fail_seen_r <= 1'h0;
    end
    else
    begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      as_prev_r <= bus.address_strobe_n;
      ds_prev_r <= ds_now;
      bad_r <= bad_nxt;
      req_r <= req_nxt;
      write_r <= write_nxt;
      long_r <= long_nxt;
      lanes_r <= lanes_nxt;
      addr_r <= addr_nxt;
      qual_r <= qual_nxt;
      test_r <= test_nxt;
      wdata_r <= wdata_nxt;
      sdata_r <= sdata_nxt;
      sdchk_r <= sdchk_nxt;
      sdata_oe_r <= sdata_oe_nxt;
      ack_oe_r <= ack_oe_nxt;
      flt_oe_r <= flt_oe_nxt;
      chk_err_r <= chk_err_nxt;
      // failure only held low or released
      fail_oe_r <= i_fail_hold;
      fail_seen_r <= ~bus.system_failure_n;
    end
  end

  assign bus.s_data_o = sdata_r;
  assign bus.s_dchk_o = sdchk_r;
  assign bus.s_data_oe = sdata_oe_r;
  assign bus.s_ack_o = bbls_pkg::LINE_LOW;
  assign bus.s_ack_oe = ack_oe_r;
  assign bus.s_flt_o = bbls_pkg::LINE_LOW;
  assign bus.s_flt_oe = flt_oe_r;
  assign bus.s_fail_o = bbls_pkg::LINE_LOW;
  assign bus.s_fail_oe = fail_oe_r;
  assign o_req = req_r;
  assign o_write = write_r;
  assign o_long = long_r;
  assign o_lanes = lanes_r;
  assign o_addr = addr_r;
  assign o_qual = qual_r;
  assign o_test = test_r;
  assign o_wdata = wdata_r;
  assign o_chk_err = chk_err_r;
  assign o_fail_seen = fail_seen_r;
endmodule : bbls_slave
`default_nettype wire

// ==== sim/bbls_checker.sv ====
// Purpose: line checks on the backplane interface
// Assumes: one clock, synchronous active-high reset
// Notes: watches resolved lines and enables
`timescale 1ns/1ps
`default_nettype none
module bbls_checker (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [31:1] address_lines,
  input wire logic write_n,
  input wire logic wide_transfer_n,
  input wire logic address_strobe_n,
  input wire logic lane0_data_strobe_n,
  input wire logic lane1_data_strobe_n,
  input wire logic transfer_acknowledge_n,
  input wire logic m_aset_oe,
  input wire logic m_data_oe,
  input wire logic s_data_oe,
  input wire logic s_ack_oe,
  input wire logic s_ack_o
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  property p_drv; !(m_data_oe && s_data_oe); endproperty
  a_drv: assert property (p_drv) else $error("two data drivers");
  property p_on; $fell(address_strobe_n) |-> $past(m_aset_oe, 2); endproperty
  a_on: assert property (p_on) else $error("strobe before drive");
  property p_hold;
    !address_strobe_n && !$past(address_strobe_n) && m_aset_oe
      |-> $stable(address_lines);
  endproperty
  a_hold: assert property (p_hold) else $error("address moved");
  property p_dir; s_data_oe |-> write_n; endproperty
  a_dir: assert property (p_dir) else $error("slave drove write");
  property p_wide;
    !wide_transfer_n && !address_strobe_n
      |-> lane0_data_strobe_n == lane1_data_strobe_n;
  endproperty
  a_wide: assert property (p_wide) else $error("lanes split");
  property p_ack;
    $fell(transfer_acknowledge_n)
      |-> !lane0_data_strobe_n || !lane1_data_strobe_n;
  endproperty
  a_ack: assert property (p_ack) else $error("ack without strobe");
  property p_oc; s_ack_oe |-> !s_ack_o; endproperty
  a_oc: assert property (p_oc) else $error("ack driven high");
  property p_end;
    $rose(address_strobe_n) |-> !m_aset_oe && !m_data_oe;
  endproperty
  a_end: assert property (p_end) else $error("lines held at end");
endmodule : bbls_checker
`default_nettype wire

// ==== sim/tb.sv ====
// Purpose: end to end transfers between master and slave
// Assumes: inputs driven on falling edge
// Notes: top address bit unmapped to force a timeout
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic i_clk = 1'h0;
  logic i_rst = 1'h1;
  logic st = 1'h0, wr = 1'h0, lg = 1'h0, gr = 1'h0, fh = 1'h0, sh = 1'h0;
  logic md, mf, mfs, sq, swr, slg, sfs, mb, sce;
  logic [1:0] ln = 2'h3, sln, stt;
  logic [7:0] sqq;
  logic [31:1] ad = 31'h0, sa, al;
  logic [31:0] wd = 32'h0, rd = 32'h0, mr, swd, cap;
  int fails = 0, comparisons = 0;
  initial forever #4 i_clk = ~i_clk;
  bbls_bus_if bus ();
  bbls_master #(.ACK_TIMEOUT(16)) bbls_master_inst (.i_clk(i_clk),
    .i_rst(i_rst), .i_start(st), .i_write(wr), .i_long(lg), .i_lanes(ln),
    .i_addr(ad), .i_qual(8'h5a), .i_test(2'h1), .i_wdata(wd), .i_grant(gr),
    .i_fail_hold(fh), .o_busy(mb), .o_done(md), .o_fault(mf), .o_rdata(mr),
    .o_fail_seen(mfs), .bus(bus));
  bbls_slave #(.MASK(31'h4000_0000)) bbls_slave_inst (.i_clk(i_clk),
    .i_rst(i_rst), .i_rdata(rd), .i_fail_hold(sh), .o_req(sq),
    .o_write(swr), .o_long(slg), .o_lanes(sln), .o_addr(sa), .o_qual(sqq),
    .o_test(stt), .o_wdata(swd), .o_chk_err(sce), .o_fail_seen(sfs),
    .bus(bus));
  bbls_checker bbls_checker_inst (.i_clk(i_clk), .i_rst(i_rst),
    .address_lines(bus.address_lines), .write_n(bus.write_n),
    .wide_transfer_n(bus.wide_transfer_n),
    .address_strobe_n(bus.address_strobe_n),
    .lane0_data_strobe_n(bus.lane0_data_strobe_n),
    .lane1_data_strobe_n(bus.lane1_data_strobe_n),
    .transfer_acknowledge_n(bus.transfer_acknowledge_n),
    .m_aset_oe(bus.m_aset_oe), .m_data_oe(bus.m_data_oe),
    .s_data_oe(bus.s_data_oe), .s_ack_oe(bus.s_ack_oe), .s_ack_o(bus.s_ack_o));

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e)
    begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  task tally_and_finish;
    $display("compares %0d mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish

  task automatic xfer(input logic w, l, input logic [1:0] n_,
                      input logic [31:1] a, input logic f);
    int n;
    @(negedge i_clk);
    st = 1'h1;
    wr = w;
    lg = l;
    ln = n_;
    ad = a;
    wd = {a, 1'h1};
    rd = ~{a, 1'h1};
    @(negedge i_clk);
    st = 1'h0;
    for (n = 0; n < 60 && md !== 1'h1; n++)
    begin
      // ownership held while grant waits
      if (n == 2 && gr !== 1'h1)
      begin
        chk({31'h0, bus.ownership_request_levels_n[0]}, 32'h0);
        chk({31'h0, mb}, 32'h1);
        gr = 1'h1;
      end
      // address is released one cycle before the strobe rises
      if (bus.address_strobe_n === 1'h0 && bus.m_aset_oe === 1'h1)
        al = bus.address_lines;
      if (sq === 1'h1)
        cap = swd;
      @(negedge i_clk);
    end
    if (n == 60)
    begin
      fails++;
      tally_and_finish();
    end
    else
    begin
      chk({31'h0, mb}, 32'h0);
      chk({31'h0, mf}, {31'h0, f});
      if (!f)
      begin
        chk({1'h0, ~al}, {1'h0, a});
        chk({1'h0, sa}, {1'h0, a});
        chk({21'h0, sce, sqq, stt}, {21'h0, 1'h0, 8'h5a, 2'h1});
        chk({30'h0, swr, slg}, {30'h0, w, l});
        chk({30'h0, sln}, {30'h0, l ? 2'h3 : n_});
        chk(w ? cap : mr, w ? wd : rd);
      end
      $display("transfer %h ended", a);
    end
  endtask : xfer

  initial
  begin
    repeat (10) @(negedge i_clk);
    i_rst = 1'h0;
    xfer(1'h1, 1'h1, 2'h3, 31'h1234_5678, 1'h0);
    xfer(1'h0, 1'h1, 2'h3, 31'h0000_0001, 1'h0);
    xfer(1'h1, 1'h0, 2'h1, 31'h3fff_fffe, 1'h0);
    xfer(1'h0, 1'h0, 2'h2, 31'h2aaa_aaaa, 1'h0);
    xfer(1'h1, 1'h0, 2'h1, 31'h4000_0002, 1'h1);
    xfer(1'h0, 1'h1, 2'h3, 31'h0555_5555, 1'h0);
    fh = 1'h1;
    repeat (3) @(negedge i_clk);
    chk({30'h0, mfs, sfs}, 32'h3);
    fh = 1'h0;
    repeat (3) @(negedge i_clk);
    chk({30'h0, mfs, sfs}, 32'h0);
    sh = 1'h1;
    repeat (3) @(negedge i_clk);
    chk({30'h0, mfs, sfs}, 32'h3);
    sh = 1'h0;
    repeat (3) @(negedge i_clk);
    chk({30'h0, mfs, sfs}, 32'h0);
    $display("failure line test ended");
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
